// ==== design/gpio_wake_pullup_altsel_subregs.sv ====
// Purpose: wake-source, pull-up and alternate-function select subregisters of one port
// Assumes: index written to the port address register picks the subregister that
//          the port control register reaches; one 10 MHz clock, sync reset
// Notes:   direction, output data and the alternate-function enable live elsewhere
//          and arrive as inputs
// Functional notes
// [RULE_01] index 05H reaches the wake-source enable
// [RULE_02] enabled pin edge in stop starts recovery
// [RULE_03] disabled pins never cause stop recovery
// [RULE_04] eight read/write wake bits, reset clear
// [RULE_05] index 06H reaches the pull-up enable
// [RULE_06] pull-up bit one turns pull-up on
// [RULE_07] index 07H reaches low select set
// [RULE_08] index 08H reaches high select set
// [RULE_09] two select bits choose one of four
// [RULE_10] software must also set enable bit
// [RULE_11] select reset 00H, small-package port A 04H
// [RULE_12] enable picks function, else plain port I/O
// [RULE_13] one wake request, only during stop
`timescale 1ns/10ps
module gpio_wake_pullup_altsel_subregs
    import gpio_cfg_pkg::*;
#(
    parameter int unsigned WIDTH         = PORT_WIDTH,
    parameter bit          SMALL_PORT_A  = 1'b0
)(
    input  wire logic                clock_i,
    input  wire logic                sys_rst_i,
    input  wire reg_req_t            req_i,
    input  wire logic                stop_mode_i,
    input  wire logic [WIDTH-1:0]    pin_i,
    input  wire logic [WIDTH-1:0]    altfunc_enable_bit_i,
    input  wire logic [WIDTH-1:0]    pin_direction_bit_i,
    input  wire logic [WIDTH-1:0]    port_out_i,
    input  wire logic [4*WIDTH-1:0]  af_out_i,
    input  wire logic [4*WIDTH-1:0]  af_oe_i,
    output logic [7:0]               rdata_o,
    output logic [7:0]               addr_reg_o,
    output logic [WIDTH-1:0]         weak_pullup_en_o,
    output logic [WIDTH-1:0]         pin_out_o,
    output logic [WIDTH-1:0]         pin_oe_o,
    output logic                     wake_req_o
);
    localparam logic [7:0] ALTSEL_RST = SMALL_PORT_A ? RST_ALTSEL_SMALL_A : RST_ALTSEL_WIDE;

    typedef enum logic [1:0] {
        RUN_ST  = 2'b01,
        STOP_ST = 2'b10
    } wake_state_t;

    logic [WIDTH-1:0] wake_source_en;
    logic [WIDTH-1:0] altfunc_sel_bit_lo;
    logic [WIDTH-1:0] altfunc_sel_bit_hi;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] pin_prev;
    logic [WIDTH-1:0] edge_hit;
    logic [7:0]       next_rdata;
    wake_state_t      wake_state;
    logic [2:0]       sync_fill;

    // index register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            addr_reg_o <= 8'h00;
        end else if (req_i.addr_wr) begin
            addr_reg_o <= req_i.wdata;
        end
    end

    // subregister writes through the control register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wake_source_en     <= RST_WAKE_SOURCE_EN[WIDTH-1:0]; // RULE_04
            weak_pullup_en_o   <= RST_PULLUP_EN[WIDTH-1:0];      // RULE_06
            altfunc_sel_bit_lo <= ALTSEL_RST[WIDTH-1:0];         // RULE_11
            altfunc_sel_bit_hi <= ALTSEL_RST[WIDTH-1:0];         // RULE_11
        end else if (req_i.ctrl_wr) begin
            case (addr_reg_o)
                IDX_WAKE_SOURCE_EN: begin
                    wake_source_en <= req_i.wdata[WIDTH-1:0];    // RULE_01
                end
                IDX_PULLUP_EN: begin
                    weak_pullup_en_o <= req_i.wdata[WIDTH-1:0];  // RULE_05
                end
                IDX_ALTSEL_LO: begin
                    altfunc_sel_bit_lo <= req_i.wdata[WIDTH-1:0]; // RULE_07
                end
                IDX_ALTSEL_HI: begin
                    altfunc_sel_bit_hi <= req_i.wdata[WIDTH-1:0]; // RULE_08
                end
                default: begin
                end
            endcase
        end
    end

    // read data; other indices belong to neighbour blocks and read zero here
    always_comb begin
        next_rdata = 8'h00;
        case (addr_reg_o)
            IDX_WAKE_SOURCE_EN: next_rdata[WIDTH-1:0] = wake_source_en;     // RULE_01
            IDX_PULLUP_EN:      next_rdata[WIDTH-1:0] = weak_pullup_en_o;   // RULE_05
            IDX_ALTSEL_LO:      next_rdata[WIDTH-1:0] = altfunc_sel_bit_lo; // RULE_07
            IDX_ALTSEL_HI:      next_rdata[WIDTH-1:0] = altfunc_sel_bit_hi; // RULE_08
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.ctrl_rd) begin
            rdata_o <= next_rdata;
        end
    end

    // pins are asynchronous to the clock
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            sync2 u_sync (
                .clock_i   (clock_i),
                .sys_rst_i (sys_rst_i),
                .d_i       (pin_i[g]),
                .q_o       (pin_sync[g])
            );
            pin_route u_route (
                .clock_i    (clock_i),
                .sys_rst_i  (sys_rst_i),
                .route_i    ({altfunc_enable_bit_i[g],
                              altfunc_sel_bit_hi[g], altfunc_sel_bit_lo[g]}), // RULE_09
                .af_out_i   (af_out_i[4*g +: 4]),
                .af_oe_i    (af_oe_i[4*g +: 4]),
                .port_out_i (port_out_i[g]),
                .dir_in_i   (pin_direction_bit_i[g]),
                .pin_out_o  (pin_out_o[g]),
                .pin_oe_o   (pin_oe_o[g])
            );
        end
    endgenerate

    // synchroniser and edge register restart at zero, so a pin idling high would
    // look like a change; edges count only once both hold real samples
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync_fill <= 3'h0;
        end else begin
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    // either direction of change counts; disabled pins are masked out
    assign edge_hit = (pin_sync ^ pin_prev) & wake_source_en
                      & {WIDTH{sync_fill[2]}}; // RULE_02 RULE_03

    // wake request held until stop mode is left
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wake_state <= RUN_ST;
            wake_req_o <= 1'b0;
        end else begin
            case (wake_state)
                RUN_ST: begin
                    wake_req_o <= 1'b0;
                    if (stop_mode_i) begin
                        wake_state <= STOP_ST;
                    end
                end
                STOP_ST: begin
                    if (!stop_mode_i) begin
                        wake_state <= RUN_ST;
                        wake_req_o <= 1'b0;               // RULE_13
                    end else if (|edge_hit) begin
                        wake_req_o <= 1'b1;               // RULE_02 RULE_13
                    end
                end
                default: begin
                    wake_state <= RUN_ST;
                    wake_req_o <= 1'b0;
                end
            endcase
        end
    end

    // checks
    chk_wake_on_edge: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_02
        (wake_state == STOP_ST && stop_mode_i && |edge_hit) |=> wake_req_o)
        else $error("enabled pin change in stop did not raise wake");

    chk_no_wake_disabled: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_03
        (wake_state == STOP_ST && !wake_req_o && stop_mode_i
         && ((pin_sync ^ pin_prev) & wake_source_en) == '0)
        |=> !wake_req_o)
        else $error("wake raised without enabled pin change");

    chk_wake_only_stop: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_13
        !stop_mode_i |=> !wake_req_o)
        else $error("wake request outside stop mode");

    chk_wake_reg_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
        (req_i.ctrl_wr && addr_reg_o == IDX_WAKE_SOURCE_EN)
        |=> wake_source_en == $past(req_i.wdata[WIDTH-1:0]))
        else $error("wake enable write not taken");

    chk_pullup_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_05
        (req_i.ctrl_wr && addr_reg_o == IDX_PULLUP_EN)
        |=> weak_pullup_en_o == $past(req_i.wdata[WIDTH-1:0]))
        else $error("pull-up write not taken");

    chk_altsel_lo_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_07
        (req_i.ctrl_wr && addr_reg_o == IDX_ALTSEL_LO)
        |=> altfunc_sel_bit_lo == $past(req_i.wdata[WIDTH-1:0]))
        else $error("low select write not taken");

    chk_altsel_hi_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_08
        (req_i.ctrl_wr && addr_reg_o == IDX_ALTSEL_HI)
        |=> altfunc_sel_bit_hi == $past(req_i.wdata[WIDTH-1:0]))
        else $error("high select write not taken");

    chk_route_select: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_12
        altfunc_enable_bit_i[0]
        |=> pin_out_o[0] == $past(af_out_i[{altfunc_sel_bit_hi[0], altfunc_sel_bit_lo[0]}]))
        else $error("pin 0 not driven by selected function");

    chk_reset_values: assert property (@(posedge clock_i) // RULE_04 RULE_11
        sys_rst_i |=> (wake_source_en == '0 && weak_pullup_en_o == '0
                       && altfunc_sel_bit_lo == ALTSEL_RST[WIDTH-1:0]
                       && altfunc_sel_bit_hi == ALTSEL_RST[WIDTH-1:0]))
        else $error("reset values wrong");

    chk_index_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
        req_i.addr_wr |=> addr_reg_o == $past(req_i.wdata))
        else $error("index write not taken");

    chk_wake_readback: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
        (req_i.ctrl_rd && addr_reg_o == IDX_WAKE_SOURCE_EN)
        |=> rdata_o[WIDTH-1:0] == $past(wake_source_en))
        else $error("wake enable readback wrong");

    chk_pullup_readback: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_05
        (req_i.ctrl_rd && addr_reg_o == IDX_PULLUP_EN)
        |=> rdata_o[WIDTH-1:0] == $past(weak_pullup_en_o))
        else $error("pull-up readback wrong");

    chk_altsel_lo_read: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_07
        (req_i.ctrl_rd && addr_reg_o == IDX_ALTSEL_LO)
        |=> rdata_o[WIDTH-1:0] == $past(altfunc_sel_bit_lo))
        else $error("low select readback wrong");

    chk_altsel_hi_read: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_08
        (req_i.ctrl_rd && addr_reg_o == IDX_ALTSEL_HI)
        |=> rdata_o[WIDTH-1:0] == $past(altfunc_sel_bit_hi))
        else $error("high select readback wrong");

    chk_wake_en_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_04
        !(req_i.ctrl_wr && addr_reg_o == IDX_WAKE_SOURCE_EN)
        |=> $stable(wake_source_en))
        else $error("wake enable changed without write");

    chk_pullup_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_06
        !(req_i.ctrl_wr && addr_reg_o == IDX_PULLUP_EN)
        |=> $stable(weak_pullup_en_o))
        else $error("pull-up changed without write");

    chk_route_port: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_12
        !altfunc_enable_bit_i[0]
        |=> (pin_out_o[0] == $past(port_out_i[0])
             && pin_oe_o[0] == !$past(pin_direction_bit_i[0])))
        else $error("pin 0 not plain port I/O");

    chk_route_enable: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_09
        altfunc_enable_bit_i[0]
        |=> pin_oe_o[0] == $past(af_oe_i[{altfunc_sel_bit_hi[0], altfunc_sel_bit_lo[0]}]))
        else $error("pin 0 enable not from selected function");

    chk_wake_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_13
        (wake_state == STOP_ST && !stop_mode_i)
        |=> (!wake_req_o && wake_state == RUN_ST))
        else $error("wake not cleared on leaving stop");
endmodule

// ==== design/pin_route.sv ====
// Purpose: one pin's choice between alternate function and plain port I/O
// Assumes: four alternate functions per pin, selected by two select bits
// Notes:   registered so the top output comes from a flip-flop
`timescale 1ns/10ps
module pin_route
    import gpio_cfg_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire pin_route_t route_i,
    input  wire logic [3:0] af_out_i,
    input  wire logic [3:0] af_oe_i,
    input  wire logic       port_out_i,
    input  wire logic       dir_in_i,
    output logic            pin_out_o,
    output logic            pin_oe_o
);
    logic next_out;
    logic next_oe;

    always_comb begin
        if (route_i.af_en) begin
            next_out = af_out_i[route_i.af_sel]; // RULE_12
            next_oe  = af_oe_i[route_i.af_sel];  // RULE_09
        end else begin
            next_out = port_out_i;               // RULE_12
            next_oe  = ~dir_in_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pin_out_o <= 1'b0;
            pin_oe_o  <= 1'b0;
        end else begin
            pin_out_o <= next_out;
            pin_oe_o  <= next_oe;
        end
    end
endmodule

// ==== design/sync2.sv ====
// Purpose: two-flop synchroniser for one pin input
// Assumes: single clock domain
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module sync2 (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ==== include/gpio_cfg_pkg.sv ====
// Purpose: shared constants and types for the port configuration subregister block
// Assumes: 8-bit port, indirect access through address and control registers
// Notes:   subregister indices as held in the port address register
package gpio_cfg_pkg;
    localparam int unsigned PORT_WIDTH = 8;

    localparam logic [7:0] IDX_WAKE_SOURCE_EN = 8'h05;
    localparam logic [7:0] IDX_PULLUP_EN      = 8'h06;
    localparam logic [7:0] IDX_ALTSEL_LO      = 8'h07;
    localparam logic [7:0] IDX_ALTSEL_HI      = 8'h08;

    localparam logic [7:0] RST_WAKE_SOURCE_EN = 8'h00;
    localparam logic [7:0] RST_PULLUP_EN      = 8'h00;
    localparam logic [7:0] RST_ALTSEL_WIDE    = 8'h00;
    localparam logic [7:0] RST_ALTSEL_SMALL_A = 8'h04;

    // register access strobes from the cpu side of the port
    typedef struct packed {
        logic       addr_wr;
        logic       ctrl_wr;
        logic       ctrl_rd;
        logic [7:0] wdata;
    } reg_req_t;

    // per-pin alternate function steering
    typedef struct packed {
        logic       af_en;
        logic [1:0] af_sel;
    } pin_route_t;
endpackage

// ==== test/pin_env.sv ====
// Purpose: far side model: external pin drivers and the stop controller
// Assumes: the bench drives every pin, so no pin floats
// Notes:   stop ends on the first edge that sees a wake request
`timescale 1ns/10ps
module pin_env (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       stop_req_i,
    input  wire logic [7:0] pin_drive_i,
    input  wire logic       wake_req_i,
    output logic            stop_mode_o,
    output logic [7:0]      pin_o
);
    assign pin_o = pin_drive_i;
    // leaving stop on wake is what lets the level request drop again
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || wake_req_i) begin
            stop_mode_o <= 1'b0;
        end else if (stop_req_i) begin
            stop_mode_o <= 1'b1;
        end
    end
endmodule

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the port configuration subregisters
// Assumes: large-package reset values, one 10 MHz clock
// Notes:   read results are checked from a queue by a watcher process
`timescale 1ns/10ps
module testbench;
    import gpio_cfg_pkg::*;
    logic        clock_i, sys_rst_i, stop_req, stop_mode, wake_req, rd_d;
    reg_req_t    req;
    logic [7:0]  pin_drive, pin_lvl, afen, dir, pout, rdata, addr_reg;
    logic [7:0]  weak_pullup_en, pin_out, pin_oe, e_out, e_oe, rdata_a;
    logic [31:0] afo, afoe, seed;
    logic [7:0]  expq[$];
    int          miscompares, checked, cycles;

    gpio_wake_pullup_altsel_subregs DUT (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req), .stop_mode_i(stop_mode),
        .pin_i(pin_lvl), .altfunc_enable_bit_i(afen), .pin_direction_bit_i(dir),
        .port_out_i(pout), .af_out_i(afo), .af_oe_i(afoe), .rdata_o(rdata),
        .addr_reg_o(addr_reg), .weak_pullup_en_o(weak_pullup_en), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .wake_req_o(wake_req));
    pin_env env (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .stop_req_i(stop_req),
        .pin_drive_i(pin_drive), .wake_req_i(wake_req), .stop_mode_o(stop_mode),
        .pin_o(pin_lvl));
    // small-package port A copy, only its read data is watched
    gpio_wake_pullup_altsel_subregs #(.SMALL_PORT_A(1'b1)) DUT_A (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req), .stop_mode_i(stop_mode),
        .pin_i(pin_lvl), .altfunc_enable_bit_i(afen), .pin_direction_bit_i(dir),
        .port_out_i(pout), .af_out_i(afo), .af_oe_i(afoe), .rdata_o(rdata_a),
        .addr_reg_o(), .weak_pullup_en_o(), .pin_out_o(), .pin_oe_o(), .wake_req_o());

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic a, input logic w, input logic r, input logic [7:0] d);
        @(posedge clock_i);
        req <= '{addr_wr: a, ctrl_wr: w, ctrl_rd: r, wdata: d};
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, idx);
        acc(1'b0, 1'b1, 1'b0, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        acc(1'b1, 1'b0, 1'b0, idx);
        acc(1'b0, 1'b0, 1'b1, 8'h00);
        expq.push_back(e);
    endtask
    task automatic settle(input int n);
        acc(1'b0, 1'b0, 1'b0, 8'h00);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic chk_reset();
        // index 04H belongs to another block and must read as zero
        for (int i = 4; i <= 8; i++) rd(8'(i), 8'h00);
        settle(2);
        cmp8(rdata_a, RST_ALTSEL_SMALL_A);
        cmp8(addr_reg, IDX_ALTSEL_HI);
    endtask
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // read data lands one edge after the read is taken
    always @(posedge clock_i) begin
        rd_d <= req.ctrl_rd;
        if (rd_d === 1'b1) begin
            cmp8(rdata, expq.pop_front());
        end
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    initial begin
        {sys_rst_i, req, stop_req, pin_drive, afen, pout, afo, afoe} = '0;
        sys_rst_i = 1'b1;
        dir = 8'hFF;
        seed = 32'haca5bd2b;
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        chk_reset();
        $display("test reset values done");
        for (int i = 5; i <= 8; i++) begin
            seed = xs(seed);
            wr(8'(i), seed[7:0]);
            rd(8'(i), seed[7:0]);
        end
        wr(8'h04, 8'h5A);
        rd(8'h04, 8'h00);
        seed = xs(seed);
        wr(IDX_PULLUP_EN, seed[7:0]);
        settle(1);
        cmp8(weak_pullup_en, seed[7:0]);
        cmp8(addr_reg, IDX_PULLUP_EN);
        $display("test register access done");
        for (int s = 0; s < 4; s++) begin
            wr(IDX_ALTSEL_LO, {8{s[0]}});
            wr(IDX_ALTSEL_HI, {8{s[1]}});
            seed = xs(seed);
            afen <= seed[7:0];
            pout <= seed[15:8];
            dir <= seed[23:16];
            afo <= xs(seed);
            seed = xs(xs(seed));
            afoe <= seed;
            settle(3);
            for (int g = 0; g < 8; g++) begin
                e_out[g] = afen[g] ? afo[4*g+s] : pout[g];
                e_oe[g] = afen[g] ? afoe[4*g+s] : ~dir[g];
            end
            cmp8(pin_out, e_out);
            cmp8(pin_oe, e_oe);
        end
        $display("test alternate routing done");
        wr(IDX_WAKE_SOURCE_EN, 8'h01);
        settle(2);
        @(posedge clock_i);
        pin_drive <= 8'h01;
        settle(8);
        cmp8({7'h0, wake_req}, 8'h00);
        @(posedge clock_i);
        stop_req <= 1'b1;
        @(posedge clock_i);
        stop_req <= 1'b0;
        settle(2);
        @(posedge clock_i);
        pin_drive <= 8'h03;
        settle(8);
        cmp8({7'h0, wake_req}, 8'h00);
        cmp8({7'h0, stop_mode}, 8'h01);
        @(posedge clock_i);
        pin_drive <= 8'h02;
        for (int k = 0; k < 8 && wake_req !== 1'b1; k++) @(posedge clock_i);
        #1;
        cmp8({7'h0, wake_req}, 8'h01);
        settle(3);
        cmp8({6'h00, wake_req, stop_mode}, 8'h00);
        // second stop, now a rising change on the enabled pin
        @(posedge clock_i);
        stop_req <= 1'b1;
        @(posedge clock_i);
        stop_req <= 1'b0;
        settle(2);
        @(posedge clock_i);
        pin_drive <= 8'h03;
        for (int k = 0; k < 8 && wake_req !== 1'b1; k++) @(posedge clock_i);
        #1;
        cmp8({7'h0, wake_req}, 8'h01);
        settle(3);
        $display("test stop wake done");
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        chk_reset();
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
